// file: design/nvs_pkg.sv
// package: pin timing, sequence addresses and counts for the nv sequencer host
package nvs_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam logic [10:0] SEQ_A0 = 11'h000;
  localparam logic [10:0] SEQ_A1 = 11'h555;
  localparam logic [10:0] SEQ_A2 = 11'h2aa;
  localparam logic [10:0] SEQ_A3 = 11'h7ff;
  localparam logic [10:0] SEQ_A4 = 11'h0f0;
  localparam logic [10:0] SEQ_SAVE = 11'h70f;
  localparam logic [10:0] SEQ_RESTORE = 11'h70e;
  localparam logic [10:0] SEQ_TEST = 11'h39c;
  localparam int unsigned SEQ_STEPS = 6;
  // chip-enable low pulse: one read access, ns
  localparam int unsigned CE_LOW_NS = 48;
  localparam int unsigned CE_LOW_CYC = (CE_LOW_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CE_HIGH_NS = 48;
  localparam int unsigned CE_HIGH_CYC = (CE_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SAVE_TIME_MS = 10;
  localparam int unsigned SAVE_CYC = SAVE_TIME_MS * CLK_MHZ * 1000;
  localparam int unsigned RESTORE_TIME_US = 20;
  localparam int unsigned RESTORE_CYC = RESTORE_TIME_US * CLK_MHZ;
  localparam int unsigned PWRUP_RESTORE_US = 650;
  localparam int unsigned PWRUP_CYC = PWRUP_RESTORE_US * CLK_MHZ;
  localparam int unsigned SEQ_OUTPUT_OFF_TIME_NS = 600;
  localparam int unsigned SEQ_OFF_CYC = (SEQ_OUTPUT_OFF_TIME_NS * CLK_MHZ + 999)
    / 1000;
  localparam int unsigned CNT_W = 22;
endpackage

// file: design/nvs_pulse_if.sv
// interface: step request between sequencer and chip-enable pulse generator
`timescale 1ns/100ps
interface nvs_pulse_if;
  logic start;
  logic [10:0] addr;
  logic busy;
  logic done;
  modport ctl (output start, output addr, input busy, input done);
  modport gen (input start, input addr, output busy, output done);
endinterface

// file: design/nvs_read_pulse.sv
// one chip-enable-controlled read with write-enable held high
`timescale 1ns/100ps
module nvs_read_pulse
  import nvs_pkg::*;
#(
  parameter int unsigned LOW_CYC = CE_LOW_CYC,
  parameter int unsigned HIGH_CYC = CE_HIGH_CYC
)(
  input wire logic i_mclk,             // clock
  input wire logic i_srst,             // sync reset
  nvs_pulse_if.gen pif,                // step request
  output logic o_ce_n,                 // chip enable, low active
  output logic [10:0] o_addr           // word_address
);
  typedef enum logic [2:0] {
    NVS_P_IDLE = 3'b001,
    NVS_P_LOW = 3'b010,
    NVS_P_HIGH = 3'b100
  } nvs_pst_e;
  nvs_pst_e st_q, st_d;
  logic [7:0] cnt_q, cnt_d;
  logic ce_n_q, ce_n_d;
  logic [10:0] addr_q, addr_d;
  logic done_q, done_d;

  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    ce_n_d = ce_n_q;
    addr_d = addr_q;
    done_d = 1'b0;
    case (st_q)
      NVS_P_IDLE:
      begin
        // address set on the same clock edge as the falling edge, one pulse per address
        if (pif.start)
        begin
          addr_d = pif.addr;
          ce_n_d = 1'b0;
          cnt_d = 8'(LOW_CYC - 1);
          st_d = NVS_P_LOW;
        end
      end
      NVS_P_LOW:
      begin
        if (cnt_q == 8'h00)
        begin
          ce_n_d = 1'b1;
          cnt_d = 8'(HIGH_CYC - 1);
          st_d = NVS_P_HIGH;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      NVS_P_HIGH:
      begin
        // address held until high time ends, then step is reported
        if (cnt_q == 8'h00)
        begin
          done_d = 1'b1;
          st_d = NVS_P_IDLE;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      default: st_d = NVS_P_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q <= NVS_P_IDLE;
      cnt_q <= 8'h00;
      ce_n_q <= 1'b1;
      addr_q <= 11'h000;
      done_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ce_n_q <= ce_n_d;
      addr_q <= addr_d;
      done_q <= done_d;
    end
  end

  assign pif.busy = (st_q != NVS_P_IDLE);
  assign pif.done = done_q;
  assign o_ce_n = ce_n_q;
  assign o_addr = addr_q;

  property p_low_width;
    @(posedge i_mclk) disable iff (i_srst)
      $fell(ce_n_q) |-> !ce_n_q [*8];
  endproperty
  a_low_width: assert property (p_low_width)
    else $error("chip enable low pulse too short");

  property p_addr_stable;
    @(posedge i_mclk) disable iff (i_srst)
      !$past(ce_n_q) |-> $stable(addr_q);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved while chip enable low");
endmodule // nvs_read_pulse

// file: design/nvs_host.sv
// host controller issuing software save/restore sequences to the nv sram
`timescale 1ns/100ps
module nvs_host
  import nvs_pkg::*;
#(
  parameter int unsigned SAVE_WAIT = SAVE_CYC,
  parameter int unsigned RESTORE_WAIT = RESTORE_CYC,
  parameter int unsigned PWRUP_WAIT = PWRUP_CYC
)(
  input wire logic i_mclk,             // 250 MHz clock
  input wire logic i_srst,             // sync reset, high
  input wire logic i_req,              // start a transfer, pulse
  input wire logic i_req_restore,      // 1 restore, 0 save, with i_req
  input wire logic i_supply_good,      // supply above switch level
  output logic o_ce_n,                 // chip enable, low active
  output logic o_we_n,                 // write enable, low active
  output logic o_oe_n,                 // output enable, low active
  output logic [10:0] o_word_address,  // word_address pins
  output logic o_busy,                 // transfer or wait running
  output logic o_done,                 // transfer finished, pulse
  output logic o_aborted               // save cut by supply low, pulse
);
  typedef enum logic [4:0] {
    NVS_PWRUP = 5'b00001,
    NVS_IDLE = 5'b00010,
    NVS_STEP = 5'b00100,
    NVS_WAIT = 5'b01000,
    NVS_DONE = 5'b10000
  } nvs_st_e;

  nvs_pulse_if pif();
  logic [10:0] pin_addr;
  logic pin_ce_n;

  nvs_read_pulse #(
    .LOW_CYC(CE_LOW_CYC),
    .HIGH_CYC(CE_HIGH_CYC)
  ) u_pulse (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .pif(pif),
    .o_ce_n(pin_ce_n),
    .o_addr(pin_addr)
  );

  nvs_st_e st_q, st_d;
  logic [2:0] step_q, step_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic restore_q, restore_d;
  logic start_q, start_d;
  logic busy_q, busy_d;
  logic done_q, done_d;
  logic abort_q, abort_d;
  logic ce_n_q;
  logic [10:0] addr_q;
  logic [10:0] step_addr;

  ////////////////////////////////////////////////////////////////////////
  // address of each step; the test address is never produced
  always_comb
  begin
    case (step_q)
      3'h0: step_addr = SEQ_A0;
      3'h1: step_addr = SEQ_A1;
      3'h2: step_addr = SEQ_A2;
      3'h3: step_addr = SEQ_A3;
      3'h4: step_addr = SEQ_A4;
      // last step picks the operation, never the test address
      3'h5: step_addr = restore_q ? SEQ_RESTORE : SEQ_SAVE;
      default: step_addr = SEQ_A0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    st_d = st_q;
    step_d = step_q;
    cnt_d = cnt_q;
    restore_d = restore_q;
    start_d = 1'b0;
    busy_d = busy_q;
    done_d = 1'b0;
    abort_d = 1'b0;
    case (st_q)
      NVS_PWRUP:
      begin
        // device restores itself once supply is good; wait out that time
        if (!i_supply_good)
          cnt_d = CNT_W'(PWRUP_WAIT);
        else if (cnt_q == '0)
        begin
          st_d = NVS_IDLE;
          busy_d = 1'b0;
        end
        else
          cnt_d = cnt_q - 1'b1;
      end
      NVS_IDLE:
      begin
        // software save is inhibited below switch level, so do not try
        if (i_req && i_supply_good)
        begin
          restore_d = i_req_restore;
          step_d = 3'h0;
          busy_d = 1'b1;
          start_d = 1'b1;
          st_d = NVS_STEP;
        end
      end
      NVS_STEP:
      begin
        // steps issued back to back with nothing else between
        if (pif.done)
        begin
          if (step_q == 3'(SEQ_STEPS - 1))
          begin
            cnt_d = restore_q ? CNT_W'(RESTORE_WAIT) : CNT_W'(SAVE_WAIT);
            st_d = NVS_WAIT;
          end
          else
          begin
            step_d = step_q + 3'h1;
            start_d = 1'b1;
          end
        end
      end
      NVS_WAIT:
      begin
        // device ignores pins now; bus stays quiet until time is over
        if (!restore_q && !i_supply_good)
        begin
          abort_d = 1'b1;
          cnt_d = CNT_W'(PWRUP_WAIT);
          st_d = NVS_PWRUP;
        end
        else if (cnt_q == '0)
          st_d = NVS_DONE;
        else
          cnt_d = cnt_q - 1'b1;
      end
      NVS_DONE:
      begin
        done_d = 1'b1;
        busy_d = 1'b0;
        st_d = NVS_IDLE;
      end
      default: st_d = NVS_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_srst)
    begin
      st_q <= NVS_PWRUP;
      step_q <= 3'h0;
      cnt_q <= CNT_W'(PWRUP_WAIT);
      restore_q <= 1'b0;
      start_q <= 1'b0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
      abort_q <= 1'b0;
      ce_n_q <= 1'b1;
      addr_q <= 11'h000;
    end
    else
    begin
      st_q <= st_d;
      step_q <= step_d;
      cnt_q <= cnt_d;
      restore_q <= restore_d;
      start_q <= start_d;
      busy_q <= busy_d;
      done_q <= done_d;
      abort_q <= abort_d;
      ce_n_q <= pin_ce_n;
      addr_q <= pin_addr;
    end
  end

  assign pif.start = start_q;
  assign pif.addr = step_addr;

  assign o_ce_n = ce_n_q;
  assign o_we_n = 1'b1;
  // output enable left high: recognition does not need it
  assign o_oe_n = 1'b1;
  assign o_word_address = addr_q;
  assign o_busy = busy_q;
  assign o_done = done_q;
  assign o_aborted = abort_q;

  ////////////////////////////////////////////////////////////////////////
  sequence s_issue;
    st_q == NVS_IDLE && i_req && i_supply_good;
  endsequence

  property p_first_addr;
    @(posedge i_mclk) disable iff (i_srst)
      s_issue |-> ##[1:6] (st_q == NVS_STEP && step_addr == SEQ_A0);
  endproperty
  a_first_addr: assert property (p_first_addr)
    else $error("sequence not started at first address");

  property p_last_addr;
    @(posedge i_mclk) disable iff (i_srst)
      (st_q == NVS_STEP && pif.done && step_q == 3'h5) |->
        (o_word_address == (restore_q ? SEQ_RESTORE : SEQ_SAVE));
  endproperty
  a_last_addr: assert property (p_last_addr)
    else $error("wrong final sequence address");

  property p_no_test;
    @(posedge i_mclk) disable iff (i_srst)
      !ce_n_q |-> addr_q != SEQ_TEST;
  endproperty
  a_no_test: assert property (p_no_test)
    else $error("factory test address issued");

  property p_quiet_wait;
    @(posedge i_mclk) disable iff (i_srst)
      st_q == NVS_WAIT |-> ##1 (ce_n_q && !pif.busy);
  endproperty
  a_quiet_wait: assert property (p_quiet_wait)
    else $error("bus active while device busy");

  property p_abort;
    @(posedge i_mclk) disable iff (i_srst)
      (st_q == NVS_WAIT && !restore_q && !i_supply_good) |->
        ##1 (o_aborted && st_q == NVS_PWRUP);
  endproperty
  a_abort: assert property (p_abort)
    else $error("save not abandoned on supply low");

  property p_restore_kept;
    @(posedge i_mclk) disable iff (i_srst)
      (st_q == NVS_WAIT && restore_q) |-> ##1 !o_aborted;
  endproperty
  a_restore_kept: assert property (p_restore_kept)
    else $error("restore abandoned on supply low");

  property p_pwrup_hold;
    @(posedge i_mclk) disable iff (i_srst)
      (st_q == NVS_PWRUP && !i_supply_good) |-> ##1 (st_q == NVS_PWRUP);
  endproperty
  a_pwrup_hold: assert property (p_pwrup_hold)
    else $error("left power-up wait without supply good");

  property p_we_high;
    @(posedge i_mclk) disable iff (i_srst)
      !o_ce_n |-> o_we_n;
  endproperty
  a_we_high: assert property (p_we_high)
    else $error("write enable low during sequence");
endmodule // nvs_host

// file: verif/nvs_dev_model.sv
// behavioural nv sram mode logic seen from its control pins
`timescale 1ns/100ps
module nvs_dev_model
  import nvs_pkg::*;
#(
  parameter real MIN_LOW_NS = 20.0,
  parameter real NV_NS = 100.0
)(
  input wire logic i_ce_n,             // chip enable, low active
  input wire logic i_we_n,             // write enable, low active
  input wire logic i_oe_n,             // output enable, never looked at
  input wire logic [10:0] i_word_address, // word_address pins
  input wire logic i_supply_good,      // supply above switch level
  output logic [7:0] o_saves,          // saves started
  output logic [7:0] o_restores,       // software restores started
  output logic [7:0] o_faults          // pin misuse seen
);
  int step = 0;
  logic armed = 1'b0;
  logic saving = 1'b0;
  logic wrote = 1'b0;
  real t_fall = 0.0;
  real nv_end = 0.0;
  logic [10:0] a_fall;
  initial
  begin
    o_saves = 8'h00;
    o_restores = 8'h00;
    o_faults = 8'h00;
  end
  function automatic logic [10:0] seq_a(input int s);
    return s == 0 ? SEQ_A0 : s == 1 ? SEQ_A1 : s == 2 ? SEQ_A2 :
      s == 3 ? SEQ_A3 : SEQ_A4;
  endfunction
  //////////////////////////////////////////////////////////////////////////
  always @(negedge i_ce_n)
  begin
    t_fall = $realtime;
    // address may move on the same edge as chip enable; let it settle
    #0.1;
    armed = (i_ce_n === 1'b0);
    a_fall = i_word_address;
  end
  // output enable is left out on purpose
  always @(posedge i_ce_n)
  begin
    if (armed && i_ce_n === 1'b1)
    begin
      armed = 1'b0;
      if ($realtime < nv_end)
      begin
        o_faults = o_faults + 8'h01; // pins ignored till done
        step = 0;
      end
      else if (i_we_n !== 1'b1 || a_fall !== i_word_address ||
        $realtime - t_fall < MIN_LOW_NS)
      begin
        o_faults = o_faults + 8'h01;
        if (i_we_n === 1'b0)
          wrote = 1'b1; // a write arms the power-down save
        step = 0;
      end
      else if (step < 5 && i_word_address === seq_a(step))
        step = step + 1; // one step per pulse
      else if (step == 5 && i_word_address === SEQ_SAVE && i_supply_good)
      begin
        o_saves = o_saves + 8'h01;
        saving = 1'b1;
        wrote = 1'b0;
        nv_end = $realtime + NV_NS; // pins and outputs off
        step = 0;
      end
      else if (step == 5 && i_word_address === SEQ_RESTORE)
      begin
        o_restores = o_restores + 8'h01;
        saving = 1'b0;
        wrote = 1'b0;
        nv_end = $realtime + NV_NS;
        step = 0;
      end
      else
      begin
        if (step == 5 && i_word_address === SEQ_TEST)
          o_faults = o_faults + 8'h01;
        step = (i_word_address === SEQ_A0) ? 1 : 0;
      end
    end
  end
  // a save dies with the supply, a restore runs on
  always @(negedge i_supply_good)
  begin
    step = 0;
    if (saving)
      nv_end = 0.0;
    saving = 1'b0;
    // a read under way keeps armed and still finishes
    // automatic save only after a write since the last transfer
    if (wrote)
    begin
      o_saves = o_saves + 8'h01;
      wrote = 1'b0;
    end
  end
  always @(posedge i_supply_good)
    nv_end = $realtime + NV_NS; // power-up restore
endmodule // nvs_dev_model

// file: verif/tb_nvs_host.sv
// testbench for the nv save/restore sequencer host
`timescale 1ns/100ps
module tb_nvs_host;
  import nvs_pkg::*;
  // short waits keep the run brief; expectations derive from them
  localparam int SW = 50;
  localparam int RW = 40;
  localparam int PW = 60;
  localparam int STEP_MAX = 6 * (CE_LOW_CYC + CE_HIGH_CYC + 4);
  logic i_mclk, i_srst, i_req, i_req_restore, i_supply_good;
  logic o_ce_n, o_we_n, o_oe_n, o_busy, o_done, o_aborted;
  logic [10:0] o_word_address;
  logic [7:0] saves, restores, faults;
  int err_count = 0;
  int n_checks = 0;
  int low_run = 0;
  int last_low = 0;
  int exp_s = 0;
  int exp_r = 0;
  int n;
  nvs_host #(.SAVE_WAIT(SW), .RESTORE_WAIT(RW), .PWRUP_WAIT(PW)) dut_u (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_req(i_req),
    .i_req_restore(i_req_restore), .i_supply_good(i_supply_good),
    .o_ce_n(o_ce_n), .o_we_n(o_we_n), .o_oe_n(o_oe_n),
    .o_word_address(o_word_address), .o_busy(o_busy), .o_done(o_done),
    .o_aborted(o_aborted));
  nvs_dev_model model_u (
    .i_ce_n(o_ce_n), .i_we_n(o_we_n), .i_oe_n(o_oe_n),
    .i_word_address(o_word_address), .i_supply_good(i_supply_good),
    .o_saves(saves), .o_restores(restores), .o_faults(faults));
  initial
  begin
    i_mclk = 1'b0;
    forever #2 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    if (o_ce_n === 1'b0)
      low_run <= low_run + 1;
    else if (low_run != 0)
    begin
      last_low <= low_run;
      low_run <= 0;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
      err_count++;
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge i_mclk);
    #1;
  endtask
  task automatic pulse_req(input logic r);
    i_req = 1'b1;
    i_req_restore = r;
    cyc(1);
    i_req = 1'b0;
  endtask
  // bounded waits: a hang shows as a failed compare, not a stall
  task automatic wait_end(input int lim);
    n = 0;
    while (o_done !== 1'b1 && o_aborted !== 1'b1 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic wait_idle(input int lim);
    n = 0;
    while (o_busy !== 1'b0 && n < lim)
    begin
      cyc(1);
      n++;
    end
  endtask
  task automatic counts();
    check(saves, exp_s);
    check(restores, exp_r);
    check(faults, 0);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_powerup();
    cyc(20);
    check(o_busy, 1);
    pulse_req(1'b0);
    i_supply_good = 1'b1;
    wait_idle(PW + 20);
    check(n >= PW - 2 && n <= PW + 4, 1);
    counts();
    $display("power-up wait done");
  endtask
  // second request mid-transfer must be dropped
  task automatic t_op(input logic r);
    pulse_req(r);
    cyc(STEP_MAX);
    pulse_req(~r);
    wait_end((r ? RW : SW) + 40);
    check(o_done, 1);
    check(o_aborted, 0);
    check(last_low, CE_LOW_CYC);
    check(o_we_n, 1);
    check(o_oe_n, 1);
    if (r)
      exp_r++;
    else
      exp_s++;
    counts();
    cyc(2);
    $display("transfer done, restore %0d", r);
  endtask
  task automatic t_abort_save();
    pulse_req(1'b0);
    cyc(STEP_MAX);
    i_supply_good = 1'b0;
    wait_end(10);
    check(o_aborted, 1);
    check(o_done, 0);
    exp_s++;
    cyc(2);
    check(o_busy, 1);
    i_supply_good = 1'b1;
    wait_idle(PW + 20);
    check(o_busy, 0);
    counts();
    $display("save abort done");
  endtask
  task automatic t_restore_dip();
    pulse_req(1'b1);
    cyc(STEP_MAX);
    i_supply_good = 1'b0;
    cyc(3);
    i_supply_good = 1'b1;
    wait_end(RW + 40);
    check(o_done, 1);
    check(o_aborted, 0);
    exp_r++;
    counts();
    $display("restore through dip done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    err_count++;
    final_report();
  end
  initial
  begin
    i_srst = 1'b1;
    i_req = 1'b0;
    i_req_restore = 1'b0;
    i_supply_good = 1'b0;
    cyc(10);
    i_srst = 1'b0;
    t_powerup();
    t_op(1'b0);
    t_op(1'b1);
    t_abort_save();
    t_restore_dip();
    final_report();
  end
endmodule // tb_nvs_host
